/* rtl/pfs_pkg.sv */
// Constants, register map and types of the phase, enable and fault supervisor.
package pfs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int SLOT_NS = 1000;
  localparam int SLOT_CYC = (SLOT_NS * CLK_MHZ) / 1000;
  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TLIM = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IOUT = 8'h0c;
  localparam logic [7:0] REG_STRAP = 8'h10;
  localparam logic [7:0] REG_BOOT = 8'h14;
  localparam logic [7:0] REG_BANKW = 8'h18;
  localparam int CTRL_CLR = 0;
  localparam int CTRL_AUTO_DIS = 2;
  localparam logic [2:0] TLIM_RST = 3'h4;
  localparam int ST_ON = 0;
  localparam int ST_RUN = 1;
  localparam int ST_TEMP = 2;
  localparam int ST_UV = 3;
  localparam int ST_OC = 4;
  localparam int ST_OV = 5;
  localparam int ST_CAT = 6;
  localparam int ST_RDY = 7;
  // ==========================================================
  // Scaling and strap decoding
  localparam logic [9:0] CMON_2P5 = 10'h307;
  localparam logic [7:0] IOUT_MAX = 8'hff;
  localparam logic [7:0] TEMP_BASE = 8'h60;
  localparam logic [6:0] ADDR_BASE = 7'h40;
  localparam logic [7:0] PIN_BOOT = 8'h55;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    S_OFF = 2'b00,
    S_SOFT = 2'b01,
    S_RUN = 2'b10,
    S_FAULT = 2'b11
  } pfs_state_t;
endpackage : pfs_pkg

/* rtl/pfs_phase_if.sv */
// Connection between the supervisor and its phase sequencer.
`timescale 1ns/100ps
interface pfs_phase_if;
  logic run;
  logic tick;
  logic [5:0] strap;
  logic [2:0] count;
  logic [5:0] fire;
  logic first_high;
  modport sup (output run, tick, strap, input count, fire, first_high);
  modport seq (input run, tick, strap, output count, fire, first_high);
endinterface : pfs_phase_if

/* rtl/pfs_bank_mem.sv */
// Configuration bank store with registered read data.
`timescale 1ns/100ps
module pfs_bank_mem #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [$clog2(D)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(D)-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D];
  initial begin
    if (D < 2) $error("bank count too small");
  end
  always_ff @(posedge aclk) begin
    if (we) mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule : pfs_bank_mem

/* rtl/pfs_phase_seq.sv */
// Phase count detection and sequential firing of the phase outputs.
`timescale 1ns/100ps
module pfs_phase_seq
  import pfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  pfs_phase_if.seq ph
);
  logic [2:0] last;
  logic [2:0] ptr;
  // Lowest strapped output among two to six ends the active set.
  always_comb begin
    last = 3'h6;
    for (int i = 5; i >= 1; i--) begin
      if (ph.strap[i]) last = 3'(i);
    end
  end
  assign ph.first_high = ph.strap[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= 3'h0;
      ph.fire <= 6'h00;
      ph.count <= 3'h6;
    end else if (!ph.run) begin
      ptr <= 3'h0;
      ph.fire <= 6'h00;
      ph.count <= last;
    end else if (ph.tick) begin
      ph.fire <= 6'(6'h01 << ptr);
      ptr <= (ptr + 3'h1 >= ph.count) ? 3'h0 : ptr + 3'h1;
    end
  end
endmodule : pfs_phase_seq

/* rtl/pfs_supervisor.sv */
// Enable, fault and strap supervisor with its register slave.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int SLOT = SLOT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic en_run_window,
  input wire logic en_off_window,
  input wire logic tm_above_on,
  input wire logic tm_below_off,
  input wire logic input_overcurrent,
  input wire logic output_overvoltage,
  input wire logic undervoltage_detect,
  input wire logic cmon_trip,
  input wire logic dvid_active,
  input wire logic soft_start_done,
  input wire logic auto_pin_grounded,
  input wire logic [5:0] phase_strap,
  input wire logic [7:0] temperature_code,
  input wire logic [9:0] cmon_code,
  input wire logic [3:0] address_step_strap,
  input wire logic [3:0] bank_boot_strap,
  output logic regulator_enable,
  output logic regulator_ready,
  output logic overtemp_warning_n,
  output logic bus_alert_n,
  output logic catastrophic_fault,
  output logic [5:0] phase_fire,
  output logic auto_drop_enable,
  output logic [6:0] bus_address,
  output logic step_10mv,
  output logic [7:0] boot_code
);
  initial begin
    if (SLOT < 1) $error("phase slot must be at least one cycle");
  end
  // ==========================================================
  // Input synchronisers
  localparam int NS = 43;
  logic [NS-1:0] sy1;
  logic [NS-1:0] sy2;
  always_ff @(posedge aclk) begin
    sy1 <= {en_run_window, en_off_window, tm_above_on, tm_below_off,
            input_overcurrent, output_overvoltage, undervoltage_detect,
            cmon_trip, dvid_active, soft_start_done, auto_pin_grounded,
            phase_strap, temperature_code, cmon_code, address_step_strap,
            bank_boot_strap};
    sy2 <= sy1;
  end
  wire en_run_s = sy2[42];
  wire en_off_s = sy2[41];
  wire tm_above_s = sy2[40];
  wire tm_below_s = sy2[39];
  wire in_oc_s = sy2[38];
  wire out_ov_s = sy2[37];
  wire uv_s = sy2[36];
  wire cmon_trip_s = sy2[35];
  wire dvid_s = sy2[34];
  wire ss_done_s = sy2[33];
  wire auto_gnd_s = sy2[32];
  wire [5:0] strap_s = sy2[31:26];
  wire [7:0] temp_s = sy2[25:18];
  wire [9:0] cmon_s = sy2[17:8];
  wire [3:0] addr_strap_s = sy2[7:4];
  wire [3:0] bank_strap_s = sy2[3:0];
  // ==========================================================
  // Register bus
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [2:0] temp_limit;
  logic auto_dis;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire do_wr = aw_hold & w_hold & ~s_axi_bvalid;
  wire wr_ctrl = do_wr & (aw_addr == REG_CTRL) & w_strb[0];
  wire wr_tlim = do_wr & (aw_addr == REG_TLIM) & w_strb[0];
  wire wr_bank = do_wr & (aw_addr == REG_BANKW) & (&w_strb[1:0]);
  wire wr_map = (aw_addr == REG_CTRL) | (aw_addr == REG_TLIM) |
                (aw_addr == REG_BANKW);
  wire clr_req = wr_ctrl & w_data[CTRL_CLR];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
    end else if (aw_hs) begin
      s_axi_awready <= 1'b0;
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_hold <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_hold <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (w_hs) begin
      s_axi_wready <= 1'b0;
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_hold <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_limit <= TLIM_RST;
      auto_dis <= 1'b0;
    end else begin
      if (wr_tlim) temp_limit <= w_data[2:0];
      if (wr_ctrl) auto_dis <= w_data[CTRL_AUTO_DIS];
    end
  end
  // ==========================================================
  // Enable qualification and fault latches
  pfs_state_t state;
  pfs_state_t next_state;
  logic pwr_on;
  logic tm_on;
  logic oc_flag;
  logic uv_flag;
  logic ov_flag;
  logic temp_flag;
  pfs_phase_if ph();
  wire tm_fall = tm_on & tm_below_s;
  wire oc_set = cmon_trip_s & ~dvid_s;
  wire cat_set = in_oc_s | out_ov_s;
  wire flt_clr = clr_req | en_off_s;
  wire fault_any = oc_flag | uv_flag | ov_flag | catastrophic_fault;
  wire go = pwr_on & tm_on & ~fault_any & ~ph.first_high;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_on <= 1'b0;
      tm_on <= 1'b0;
    end else begin
      if (en_off_s) pwr_on <= 1'b0;
      else if (en_run_s) pwr_on <= 1'b1;
      if (tm_below_s) tm_on <= 1'b0;
      else if (tm_above_s) tm_on <= 1'b1;
    end
  end
  // Supply reset is the only way out of the catastrophic latch.
  always_ff @(posedge aclk) begin
    if (!aresetn) catastrophic_fault <= 1'b0;
    else if (cat_set) catastrophic_fault <= 1'b1;
  end
  // A set arriving with a clear wins, so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_flag <= 1'b0;
      uv_flag <= 1'b0;
      ov_flag <= 1'b0;
      temp_flag <= 1'b0;
    end else begin
      oc_flag <= oc_set | (oc_flag & ~flt_clr);
      uv_flag <= uv_s | (uv_flag & ~flt_clr);
      ov_flag <= out_ov_s | (ov_flag & ~flt_clr);
      temp_flag <= tm_fall | (temp_flag & ~flt_clr);
    end
  end
  always_comb begin
    next_state = state;
    unique case (state)
      S_OFF: if (go) next_state = S_SOFT;
      S_SOFT: if (ss_done_s) next_state = S_RUN;
      S_RUN: next_state = S_RUN;
      S_FAULT: if (!fault_any) next_state = S_OFF;
    endcase
    if (fault_any) next_state = S_FAULT;
    else if (!pwr_on || !tm_on || ph.first_high) next_state = S_OFF;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) state <= S_OFF;
    else state <= next_state;
  end
  // ==========================================================
  // Outputs and phase sequencing
  logic [$clog2(SLOT+1)-1:0] slot_cnt;
  logic tick;
  logic strap_done;
  logic [2:0] bank_sel;
  logic boot_pin;
  logic [7:0] mem_rdata;
  logic [7:0] iout;
  wire hot = temp_s > (TEMP_BASE + {2'h0, temp_limit, 3'h0});
  wire run_now = (next_state == S_SOFT) | (next_state == S_RUN);
  always_ff @(posedge aclk) begin
    if (!aresetn || !regulator_enable || slot_cnt == 0) begin
      slot_cnt <= ($clog2(SLOT+1))'(SLOT - 1);
    end else begin
      slot_cnt <= slot_cnt - 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) tick <= 1'b0;
    else tick <= regulator_enable & (slot_cnt == 0);
  end
  assign ph.run = regulator_enable;
  assign ph.tick = tick;
  assign ph.strap = strap_s;
  pfs_phase_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ph(ph)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regulator_enable <= 1'b0;
      regulator_ready <= 1'b0;
      overtemp_warning_n <= 1'b1;
      bus_alert_n <= 1'b1;
      phase_fire <= 6'h00;
      auto_drop_enable <= 1'b0;
    end else begin
      regulator_enable <= run_now;
      regulator_ready <= (state == S_RUN) & ~fault_any;
      overtemp_warning_n <= ~hot;
      bus_alert_n <= ~(fault_any | temp_flag);
      phase_fire <= ph.fire;
      auto_drop_enable <= ~(auto_gnd_s | auto_dis);
    end
  end
  // Address, step and bank straps are read once, on the first edge after reset release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done <= 1'b0;
      bus_address <= ADDR_BASE;
      step_10mv <= 1'b0;
      bank_sel <= 3'h0;
      boot_pin <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      bus_address <= ADDR_BASE | {4'h0, addr_strap_s[2:0]};
      step_10mv <= addr_strap_s[3];
      bank_sel <= bank_strap_s[2:0];
      boot_pin <= bank_strap_s[3];
    end
  end
  pfs_bank_mem #(.W(8), .D(8)) u_mem (
    .aclk(aclk),
    .we(wr_bank),
    .waddr(w_data[10:8]),
    .wdata(w_data[7:0]),
    .raddr(bank_sel),
    .rdata(mem_rdata)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) boot_code <= PIN_BOOT;
    else boot_code <= boot_pin ? PIN_BOOT : mem_rdata;
  end
  // Full-scale reading at the 2.5V level, clamped above it.
  always_ff @(posedge aclk) begin
    if (!aresetn) iout <= 8'h00;
    else if (cmon_s >= CMON_2P5) iout <= IOUT_MAX;
    else iout <= 8'((18'(cmon_s) * 18'd255) / 18'(CMON_2P5));
  end
  // ==========================================================
  // Register read port
  logic [31:0] rd_mux;
  wire rd_map = (s_axi_araddr <= REG_BANKW) & (s_axi_araddr[1:0] == 2'h0);
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      REG_CTRL: rd_mux[CTRL_AUTO_DIS] = auto_dis;
      REG_TLIM: rd_mux[2:0] = temp_limit;
      REG_STATUS: rd_mux[7:0] = {regulator_ready, catastrophic_fault, ov_flag,
                                 oc_flag, uv_flag, temp_flag, state == S_RUN,
                                 regulator_enable};
      REG_IOUT: rd_mux[7:0] = iout;
      REG_STRAP: rd_mux[15:0] = {ph.count, step_10mv, bank_sel,
                                 bus_address, boot_pin, 1'b0};
      REG_BOOT: rd_mux[7:0] = boot_code;
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  cat_latch_a: assert property (cat_set |=> catastrophic_fault [*3])
    else $error("catastrophic latch did not set and hold");
  cat_keep_a: assert property (catastrophic_fault && en_off_s |=>
    catastrophic_fault) else $error("catastrophic latch cleared");
  off_clear_a: assert property (en_off_s && !uv_s && !oc_set |=>
    !uv_flag && !oc_flag && !pwr_on) else $error("faults kept on shutdown");
  rdy_fault_a: assert property (fault_any |=> !regulator_ready)
    else $error("ready released during fault");
  rdy_soft_a: assert property ($rose(regulator_ready) |->
    $past(state == S_RUN)) else $error("ready before soft-start end");
  tm_hyst_a: assert property (tm_below_s |=>
    !tm_on ##1 !regulator_enable) else $error("temperature disable ignored");
  temp_flag_a: assert property (tm_fall |=> temp_flag)
    else $error("overtemperature flag not set");
  hot_out_a: assert property (hot |=> !overtemp_warning_n)
    else $error("overtemperature output not driven");
  dvid_mask_a: assert property (dvid_s && !oc_flag |=> !oc_flag)
    else $error("overcurrent tripped during transition");
  auto_off_a: assert property (auto_gnd_s |=> !auto_drop_enable)
    else $error("phase dropping left enabled");
  first_hold_a: assert property (ph.first_high |=> !regulator_enable)
    else $error("enabled with first phase high");
  run_c: cover property (state == S_SOFT ##[1:20] state == S_RUN);
  cat_c: cover property ($rose(catastrophic_fault));
  clr_c: cover property (temp_flag && clr_req ##1 !temp_flag);
endmodule : pfs_supervisor

/* verif/pfs_stage_model.sv */
// Power-stage model that reports soft-start completion after a delay.
`timescale 1ns/100ps
module pfs_stage_model #(
  parameter int DELAY = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic regulator_enable,
  output logic soft_start_done
);
  int cnt;
  // Soft-start finishes a fixed delay after the stage is enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn || !regulator_enable) begin
      cnt <= 0;
      soft_start_done <= 1'b0;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end else begin
      soft_start_done <= 1'b1;
    end
  end
endmodule : pfs_stage_model

/* verif/test_pfs_supervisor.sv */
// Self-checking bench of the phase, enable and fault supervisor.
`timescale 1ns/100ps
module test_pfs_supervisor;
  import pfs_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, regulator_enable, regulator_ready, step_10mv;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic en_run_window = 1'b0, en_off_window = 1'b0;
  logic tm_above_on = 1'b1, tm_below_off = 1'b0, dvid_active = 1'b0;
  logic input_overcurrent = 1'b0, output_overvoltage = 1'b0;
  logic undervoltage_detect = 1'b0, cmon_trip = 1'b0;
  logic auto_pin_grounded = 1'b0, soft_start_done;
  logic [5:0] phase_strap = 6'h08, phase_fire;
  logic [7:0] temperature_code = 8'h20, boot_code;
  logic [9:0] cmon_code = 10'h000;
  logic [3:0] address_step_strap = 4'hb, bank_boot_strap = 4'hd;
  logic overtemp_warning_n, bus_alert_n, catastrophic_fault;
  logic auto_drop_enable;
  logic [6:0] bus_address;
  int n_errors = 0, n_compared = 0;
  always #2 aclk = ~aclk;
  pfs_supervisor #(.SLOT(4)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .en_run_window, .en_off_window, .tm_above_on, .tm_below_off,
    .input_overcurrent, .output_overvoltage, .undervoltage_detect,
    .cmon_trip, .dvid_active, .soft_start_done, .auto_pin_grounded,
    .phase_strap, .temperature_code, .cmon_code, .address_step_strap,
    .bank_boot_strap, .regulator_enable, .regulator_ready,
    .overtemp_warning_n, .bus_alert_n, .catastrophic_fault, .phase_fire,
    .auto_drop_enable, .bus_address, .step_10mv, .boot_code);
  pfs_stage_model #(.DELAY(3)) stage (.aclk, .aresetn, .regulator_enable,
    .soft_start_done);
  // ==========================================================
  // Comparison, closing and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    bit aw, w;
    int i;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50 && !(aw && w); i++) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) @(posedge aclk);
    s_axi_bready <= 1'b0;
    if (!(aw && w) || i == 50) begin
      n_errors++;
      close_out();
    end
    check(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (s_axi_arready !== 1'b1 && i < 50);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
    end while (s_axi_rvalid !== 1'b1 && i < 100);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin
      n_errors++;
      close_out();
    end
    d = s_axi_rdata;
    check(32'(s_axi_rresp), 32'(er));
  endtask : rd
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [5:0] last;
    int k, chg;
    logic [7:0] tt [4] = '{8'h81, 8'h80, 8'h99, 8'h98};
    logic [9:0] ic [4] = '{10'd0, 10'd310, 10'd775, 10'd1023};
    logic [7:0] ie [4] = '{8'd0, 8'd102, 8'hff, 8'hff};
    settle(5);
    aresetn <= 1'b1;
    settle(4);
    check(32'(boot_code), 32'(PIN_BOOT));
    check(32'(bus_address), 32'h43);
    check(32'(step_10mv), 32'h1);
    check(32'(auto_drop_enable), 32'h1);
    rd(REG_STRAP, RESP_OKAY, d);
    check(d, 32'h7b0e);
    en_run_window <= 1'b1;
    settle(20);
    check(32'(regulator_ready), 32'h1);
    rd(REG_STATUS, RESP_OKAY, d);
    check(d & 32'h83, 32'h83);
    last = 6'h00;
    chg = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (phase_fire !== 6'h00 && phase_fire !== last) begin
        if (last !== 6'h00) begin
          check(32'(phase_fire), 32'(last == 6'h04 ? 6'h01 : last << 1));
        end
        last = phase_fire;
        chg++;
      end
    end
    check(32'(chg > 5), 32'h1);
    dvid_active <= 1'b1;
    cmon_trip <= 1'b1;
    settle(10);
    check(32'(regulator_ready), 32'h1);
    dvid_active <= 1'b0;
    settle(8);
    check(32'(regulator_ready), 32'h0);
    check(32'(bus_alert_n), 32'h0);
    rd(REG_STATUS, RESP_OKAY, d);
    check(32'(d[ST_OC]), 32'h1);
    cmon_trip <= 1'b0;
    wr(REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
    settle(20);
    check(32'(regulator_ready), 32'h1);
    check(32'(bus_alert_n), 32'h1);
    tm_above_on <= 1'b0;
    tm_below_off <= 1'b1;
    settle(8);
    check(32'(regulator_enable), 32'h0);
    rd(REG_STATUS, RESP_OKAY, d);
    check(32'(d[ST_TEMP]), 32'h1);
    tm_below_off <= 1'b0;
    tm_above_on <= 1'b1;
    settle(6);
    wr(REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
    settle(20);
    check(32'(regulator_enable), 32'h1);
    rd(REG_STATUS, RESP_OKAY, d);
    check(32'(d[ST_TEMP]), 32'h0);
    for (k = 0; k < 4; k++) begin
      if (k == 2) begin
        wr(REG_TLIM, 32'h7, 4'hf, RESP_OKAY);
        wr(REG_TLIM, 32'h2, 4'h0, RESP_OKAY);
        rd(REG_TLIM, RESP_OKAY, d);
        check(d, 32'h7);
      end
      temperature_code <= tt[k];
      cmon_code <= ic[k];
      settle(6);
      check(32'(overtemp_warning_n), 32'(k[0]));
      rd(REG_IOUT, RESP_OKAY, d);
      check(d, 32'(ie[k]));
    end
    temperature_code <= 8'h20;
    wr(REG_CTRL, 32'h4, 4'hf, RESP_OKAY);
    settle(4);
    check(32'(auto_drop_enable), 32'h0);
    rd(REG_CTRL, RESP_OKAY, d);
    check(d, 32'h4);
    wr(REG_CTRL, 32'h0, 4'hf, RESP_OKAY);
    auto_pin_grounded <= 1'b1;
    settle(6);
    check(32'(auto_drop_enable), 32'h0);
    wr(8'h1c, 32'h1, 4'hf, RESP_SLVERR);
    rd(8'h1c, RESP_SLVERR, d);
    undervoltage_detect <= 1'b1;
    settle(6);
    undervoltage_detect <= 1'b0;
    settle(4);
    check(32'(regulator_ready), 32'h0);
    en_run_window <= 1'b0;
    en_off_window <= 1'b1;
    settle(6);
    check(32'(regulator_enable), 32'h0);
    rd(REG_STATUS, RESP_OKAY, d);
    check(32'(d[ST_UV]), 32'h0);
    en_off_window <= 1'b0;
    en_run_window <= 1'b1;
    settle(20);
    check(32'(regulator_ready), 32'h1);
    input_overcurrent <= 1'b1;
    settle(6);
    input_overcurrent <= 1'b0;
    check(32'(catastrophic_fault), 32'h1);
    check(32'(regulator_ready), 32'h0);
    en_run_window <= 1'b0;
    en_off_window <= 1'b1;
    tm_above_on <= 1'b0;
    tm_below_off <= 1'b1;
    settle(8);
    wr(REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
    settle(4);
    check(32'(catastrophic_fault), 32'h1);
    aresetn <= 1'b0;
    phase_strap <= 6'h01;
    bank_boot_strap <= 4'h2;
    en_off_window <= 1'b0;
    en_run_window <= 1'b1;
    tm_below_off <= 1'b0;
    tm_above_on <= 1'b1;
    settle(5);
    aresetn <= 1'b1;
    settle(20);
    check(32'(catastrophic_fault), 32'h0);
    check(32'(regulator_enable), 32'h0);
    wr(REG_BANKW, 32'h23c, 4'h3, RESP_OKAY);
    settle(4);
    check(32'(boot_code), 32'h3c);
    rd(REG_BOOT, RESP_OKAY, d);
    check(d, 32'h3c);
    output_overvoltage <= 1'b1;
    settle(6);
    check(32'(catastrophic_fault), 32'h1);
    close_out();
  end
endmodule : test_pfs_supervisor
